// ### bfe_top.sv
// Bit-field extractor with an APB register file.
// Assumes operands arrive synchronous to CLK with a one-cycle valid strobe.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
// Overview of operation
// - Result is operand shifted right, then recast.
// - Negative position counts down from the MSB.
// - Position vector gives vector output from scalar.
// - Output lanes follow position vector order.
// - Vector input pairs each lane with element.
// - Non-Boolean types split word into lanes.
// - Inherited type sizes from input bit counts.
// - Specified type reinterprets bits from LSB up.
// - Boolean mode yields one bit per lane.
// - Position picks which bit becomes bit zero.
module bfe_top
  import bfe_pkg::*;
(
  // Clock and reset.
  input  wire logic             CLK,
  input  wire logic             RSTN,
  // APB slave.
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [AW-1:0]    PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  // Operand from the datapath.
  input  wire logic [SRC_W-1:0] OPERAND,
  input  wire logic             OPERAND_VALID,
  // Result to the datapath.
  output logic [LANES*OUT_W-1:0] RESULT,
  output logic                   RESULT_VALID
);

  logic                   rst_meta_ff;
  logic                   rst_sync_ff;
  logic                   rst_n;

  logic [3:0]             ctrl_ff;
  logic [7:0]             in_int_ff;
  logic [7:0]             in_frac_ff;
  logic                   in_sign_ff;
  logic [7:0]             out_wid_ff;
  logic [7:0]             out_frac_ff;
  logic [LANES*8-1:0]     pos_ff;
  logic                   range_err_ff;
  logic [31:0]            count_ff;
  logic [LANES*OUT_W-1:0] result_ff;
  logic                   result_valid_ff;

  logic [3:0]             nxt_ctrl;
  logic [7:0]             nxt_in_int;
  logic [7:0]             nxt_in_frac;
  logic                   nxt_in_sign;
  logic [7:0]             nxt_out_wid;
  logic [7:0]             nxt_out_frac;
  logic [LANES*8-1:0]     nxt_pos;
  logic                   nxt_range_err;
  logic [31:0]            nxt_count;
  logic [LANES*OUT_W-1:0] nxt_result;
  logic                   nxt_result_valid;

  logic                   wr_stb;
  logic                   addr_ok;
  logic [31:0]            rdata;
  logic                   vec_in;
  logic                   sign_ext;
  logic [8:0]             width_sum;
  logic [7:0]             in_width;
  logic [5:0]             eff_width;
  logic                   cfg_err;
  logic [LANES*OUT_W-1:0] lane_value;
  logic [LANES-1:0]       lane_oor;
  logic [LANES-1:0]       res_hit;
  logic [SRC_W-1:0]       lane_src [LANES];
  bfe_mode_type           mode;

  // The reset is released through two flops so every register leaves reset on one edge.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign rst_n = rst_sync_ff;

  // The slave answers every access in one cycle, so writes land at its completing edge.
  bfe_apb u_apb (
    .clk      (CLK),
    .rst_n    (rst_n),
    .psel     (PSEL),
    .penable  (PENABLE),
    .pwrite   (PWRITE),
    .rdata_in (rdata),
    .addr_ok  (addr_ok),
    .prdata   (PRDATA),
    .pready   (PREADY),
    .pslverr  (PSLVERR),
    .wr_stb   (wr_stb)
  );

  // Bad widths other than a zero input width are clamped here, so a wrong setting shows in STATUS and not in the lanes.
  // Output format selection.
  always_comb begin
    mode     = bfe_mode_type'(ctrl_ff[CTRL_MODE_LSB +: 2]);
    vec_in   = ctrl_ff[CTRL_VEC_BIT];
    // Inherit sums integer and fraction bits.
    width_sum = {1'b0, in_int_ff} + {1'b0, in_frac_ff};
    if (width_sum > 9'(SRC_W)) begin
      in_width = 8'(SRC_W);
    end else begin
      in_width = width_sum[7:0];
    end
    cfg_err  = (width_sum == 9'h000) || (width_sum > 9'(SRC_W));
    if (vec_in && (width_sum > 9'(ELEM_W))) begin
      in_width = 8'(ELEM_W);
      cfg_err  = 1'b1;
    end
    eff_width = 6'h01;
    sign_ext  = 1'b0;
    unique case (mode)
      BFE_INHERIT: begin
        eff_width = (in_width > 8'(OUT_W)) ? 6'(OUT_W) : in_width[5:0];
        sign_ext  = in_sign_ff;
      end
      BFE_SPECIFY: begin
        eff_width = (out_wid_ff > 8'(OUT_W)) ? 6'(OUT_W) : out_wid_ff[5:0];
        sign_ext  = ctrl_ff[CTRL_SIGN_BIT];
      end
      BFE_BOOLEAN: begin
        eff_width = 6'h01;
        sign_ext  = 1'b0;
      end
      default: begin
        eff_width = 6'h01;
        sign_ext  = 1'b0;
      end
    endcase
    if (eff_width == 6'h00) begin
      eff_width = 6'h01;
    end
  end

  generate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
      // Vector input pairs lane with element.
      assign lane_src[g] = vec_in ? SRC_W'(OPERAND[g*ELEM_W +: ELEM_W]) : OPERAND;
      // Each lane's held result has its own word in the register map.
      assign res_hit[g] = (PADDR == AW'(RES0_OFS + 8'(4 * g)));
      bfe_lane u_lane (
        .src          (lane_src[g]),
        .in_width     (in_width),
        .pos          (pos_ff[g*POS_W +: POS_W]),
        .out_width    (eff_width),
        .sign_ext     (sign_ext),
        .value        (lane_value[g*OUT_W +: OUT_W]),
        .out_of_range (lane_oor[g])
      );
    end
  endgenerate

  // Register read mux and address decode.
  // Unmapped words are refused with an error and read as zero.
  always_comb begin
    addr_ok = 1'b1;
    rdata   = 32'h0000_0000;
    unique case (PADDR)
      CTRL_OFS:    rdata = 32'(ctrl_ff);
      IN_FMT_OFS:  rdata = {15'h0000, in_sign_ff, in_frac_ff, in_int_ff};
      OUT_FMT_OFS: rdata = {16'h0000, out_frac_ff, out_wid_ff};
      POS_OFS:     rdata = pos_ff;
      STATUS_OFS:  rdata = {16'h0000, 2'h0, eff_width, 6'h00, range_err_ff, cfg_err};
      COUNT_OFS:   rdata = count_ff;
      default: begin
        addr_ok = |res_hit;
        for (int i = 0; i < LANES; i++) begin
          if (res_hit[i]) begin
            rdata = 32'(result_ff[i*OUT_W +: OUT_W]);
          end
        end
      end
    endcase
  end

  // Configuration register writes.
  always_comb begin
    nxt_ctrl     = ctrl_ff;
    nxt_in_int   = in_int_ff;
    nxt_in_frac  = in_frac_ff;
    nxt_in_sign  = in_sign_ff;
    nxt_out_wid  = out_wid_ff;
    nxt_out_frac = out_frac_ff;
    nxt_pos      = pos_ff;
    if (wr_stb) begin
      unique case (PADDR)
        CTRL_OFS: begin
          nxt_ctrl = PWDATA[3:0];
        end
        IN_FMT_OFS: begin
          nxt_in_int  = PWDATA[IN_INT_LSB +: 8];
          nxt_in_frac = PWDATA[IN_FRAC_LSB +: 8];
          nxt_in_sign = PWDATA[IN_SIGN_BIT];
        end
        OUT_FMT_OFS: begin
          nxt_out_wid  = PWDATA[OUT_WID_LSB +: 8];
          nxt_out_frac = PWDATA[OUT_FRAC_LSB +: 8];
        end
        POS_OFS: begin
          nxt_pos = PWDATA[LANES*8-1:0];
        end
        default: begin
          nxt_pos = pos_ff;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff     <= CTRL_RST;
      in_int_ff   <= IN_INT_RST;
      in_frac_ff  <= IN_FRAC_RST;
      in_sign_ff  <= 1'b0;
      out_wid_ff  <= OUT_WID_RST;
      out_frac_ff <= OUT_FRAC_RST;
      pos_ff      <= POS_RST;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      in_int_ff   <= nxt_in_int;
      in_frac_ff  <= nxt_in_frac;
      in_sign_ff  <= nxt_in_sign;
      out_wid_ff  <= nxt_out_wid;
      out_frac_ff <= nxt_out_frac;
      pos_ff      <= nxt_pos;
    end
  end

  // Sticky range error and operand counter.
  // Writing COUNT clears it; an operand in that same cycle still counts as one.
  always_comb begin
    nxt_range_err = range_err_ff;
    nxt_count     = count_ff;
    if (wr_stb && (PADDR == STATUS_OFS) && PWDATA[ST_RANGE_BIT]) begin
      nxt_range_err = 1'b0;
    end
    if (wr_stb && (PADDR == COUNT_OFS)) begin
      nxt_count = 32'h0000_0000;
    end
    // A new range fault wins over a clear in the same cycle.
    if (OPERAND_VALID) begin
      nxt_count = nxt_count + 32'h0000_0001;
      if (|lane_oor) begin
        nxt_range_err = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      range_err_ff <= 1'b0;
      count_ff     <= 32'h0000_0000;
    end else begin
      range_err_ff <= nxt_range_err;
      count_ff     <= nxt_count;
    end
  end

  // Result lanes are captured only on a valid operand and then held.
  always_comb begin
    nxt_result       = result_ff;
    nxt_result_valid = OPERAND_VALID;
    if (OPERAND_VALID) begin
      nxt_result = lane_value;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      result_ff       <= '0;
      result_valid_ff <= 1'b0;
    end else begin
      result_ff       <= nxt_result;
      result_valid_ff <= nxt_result_valid;
    end
  end

  // The fraction count only scales the value for software; the bits are not moved by it.
  assign RESULT       = result_ff;
  assign RESULT_VALID = result_valid_ff;

endmodule

// ### bfe_pkg.sv
// Constants, register map and types for the bit-field extractor.
// Assumes a single 250 MHz clock domain and an APB register bus.
package bfe_pkg;

  localparam int LANES  = 4;
  localparam int ELEM_W = 32;
  localparam int SRC_W  = LANES * ELEM_W;
  localparam int OUT_W  = 32;
  localparam int POS_W  = 8;
  localparam int AW     = 8;

  localparam logic [AW-1:0] CTRL_OFS    = 8'h00;
  localparam logic [AW-1:0] IN_FMT_OFS  = 8'h04;
  localparam logic [AW-1:0] OUT_FMT_OFS = 8'h08;
  localparam logic [AW-1:0] POS_OFS     = 8'h0C;
  localparam logic [AW-1:0] STATUS_OFS  = 8'h10;
  localparam logic [AW-1:0] COUNT_OFS   = 8'h14;
  localparam logic [AW-1:0] RES0_OFS    = 8'h20;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SIGN_BIT = 2;
  localparam int CTRL_VEC_BIT  = 3;
  localparam int IN_INT_LSB    = 0;
  localparam int IN_FRAC_LSB   = 8;
  localparam int IN_SIGN_BIT   = 16;
  localparam int OUT_WID_LSB   = 0;
  localparam int OUT_FRAC_LSB  = 8;
  localparam int ST_CFG_BIT    = 0;
  localparam int ST_RANGE_BIT  = 1;

  localparam logic [3:0]         CTRL_RST     = 4'h0;
  localparam logic [7:0]         IN_INT_RST   = 8'h20;
  localparam logic [7:0]         IN_FRAC_RST  = 8'h00;
  localparam logic [7:0]         OUT_WID_RST  = 8'h08;
  localparam logic [7:0]         OUT_FRAC_RST = 8'h00;
  localparam logic [LANES*8-1:0] POS_RST      = 32'h1810_0800;

  typedef enum logic [1:0] {
    BFE_INHERIT = 2'h0,
    BFE_SPECIFY = 2'h1,
    BFE_BOOLEAN = 2'h3
  } bfe_mode_type;

endpackage

// ### bfe_lane.sv
// One extraction lane: shift a source word down and recast it.
// Assumes the caller clamps the output width to 1..OUT_W.
`timescale 1ns/1ns
module bfe_lane
  import bfe_pkg::*;
(
  // Source operand and its format.
  input  wire logic [SRC_W-1:0] src,
  input  wire logic [7:0]       in_width,
  // Selected position, may be negative.
  input  wire logic [POS_W-1:0] pos,
  // Output format.
  input  wire logic [5:0]       out_width,
  input  wire logic             sign_ext,
  // Result.
  output logic      [OUT_W-1:0] value,
  output logic                  out_of_range
);

  logic [8:0]       eff;
  logic [SRC_W-1:0] masked;
  logic [SRC_W-1:0] shifted;
  logic             top_bit;

  always_comb begin
    if (pos[POS_W-1]) begin
      eff = {1'b0, in_width} + {pos[POS_W-1], pos};
    end else begin
      eff = {1'b0, pos};
    end
    out_of_range = eff[8] || (eff[7:0] >= in_width);
    for (int i = 0; i < SRC_W; i++) begin
      masked[i] = src[i] & (i < int'(in_width));
    end
    shifted = eff[8] ? '0 : (masked >> eff[7:0]);
    top_bit = shifted[out_width - 6'h01];
    for (int i = 0; i < OUT_W; i++) begin
      value[i] = (i < int'(out_width)) ? shifted[i] : (sign_ext & top_bit);
    end
  end

endmodule

// ### bfe_apb.sv
// APB slave handshake for the extractor's register file.
// Assumes the parent decodes the address and supplies read data.
`timescale 1ns/1ns
module bfe_apb
  import bfe_pkg::*;
(
  // Clock and synchronised reset.
  input  wire logic          clk,
  input  wire logic          rst_n,
  // APB request.
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  // Decode results from the parent.
  input  wire logic [31:0]   rdata_in,
  input  wire logic          addr_ok,
  // APB answer.
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Write strobe at the completing edge.
  output logic               wr_stb
);

  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] nxt_prdata;
  logic        nxt_pready;
  logic        nxt_pslverr;
  logic        setup;

  // The answer is prepared in the setup cycle, so every access ends in one wait-free cycle.
  always_comb begin
    setup       = psel & ~penable;
    nxt_pready  = setup;
    nxt_pslverr = setup & ~addr_ok;
    nxt_prdata  = prdata_ff;
    if (setup) begin
      nxt_prdata = (addr_ok && !pwrite) ? rdata_in : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign wr_stb  = psel & penable & pwrite & pready_ff & ~pslverr_ff;

endmodule

// ### bfe_checker.sv
// Port-level checks for the bit-field extractor top module.
// Assumes CLK is the only clock and RSTN is the raw reset pin.
`timescale 1ns/1ns
module bfe_checker
  import bfe_pkg::*;
(
  // Clock and reset.
  input wire logic                   CLK,
  input wire logic                   RSTN,
  // APB.
  input wire logic                   PSEL,
  input wire logic                   PENABLE,
  input wire logic                   PWRITE,
  input wire logic [AW-1:0]          PADDR,
  input wire logic [31:0]            PWDATA,
  input wire logic [31:0]            PRDATA,
  input wire logic                   PREADY,
  input wire logic                   PSLVERR,
  // Datapath.
  input wire logic [SRC_W-1:0]       OPERAND,
  input wire logic                   OPERAND_VALID,
  input wire logic [LANES*OUT_W-1:0] RESULT,
  input wire logic                   RESULT_VALID
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  result_latency_a: assert property (OPERAND_VALID |=> RESULT_VALID)
    else $error("result valid late");
  result_idle_a: assert property (!OPERAND_VALID |=> !RESULT_VALID)
    else $error("stray result valid");
  result_hold_a: assert property (!RESULT_VALID |-> $stable(RESULT))
    else $error("result moved without valid");
  reset_clear_a: assert property ($rose(RSTN) |-> !RESULT_VALID && !PREADY && RESULT == '0)
    else $error("outputs not clear after reset");
  ready_phase_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access phase");
  ready_answer_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready in access phase");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  error_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  error_data_a: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0000_0000)
    else $error("refused read data not zero");
endmodule
bind bfe_top bfe_checker i_bfe_checker (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .OPERAND(OPERAND), .OPERAND_VALID(OPERAND_VALID),
  .RESULT(RESULT), .RESULT_VALID(RESULT_VALID));

// ### bfe_dp_model.sv
// Datapath partner that feeds operands and collects results.
// Assumes it shares CLK with the extractor and results return in order.
`timescale 1ns/1ns
module bfe_dp_model
  import bfe_pkg::*;
(
  // Clock.
  input  wire logic                   clk,
  // Operand to the extractor.
  output logic      [SRC_W-1:0]       operand,
  output logic                        operand_valid,
  // Result from the extractor.
  input  wire logic [LANES*OUT_W-1:0] result,
  input  wire logic                   result_valid
);
  logic [LANES*OUT_W-1:0] got_q[$];
  initial begin
    operand = '0;
    operand_valid = 1'b0;
  end
  // Element i travels at bits 32i+31:32i.
  task automatic put(input logic [SRC_W-1:0] op);
    @(posedge clk);
    operand <= op;
    operand_valid <= 1'b1;
  endtask
  // Idle bus shows inverted bits so a stale operand cannot look valid.
  task automatic idle();
    @(posedge clk);
    operand_valid <= 1'b0;
    operand <= ~operand;
  endtask
  always @(posedge clk) begin
    if (result_valid === 1'b1) begin
      got_q.push_back(result);
    end
  end
endmodule

// ### bit_field_extract_tb_top.sv
// Self-checking bench for the extractor through APB and the datapath.
// Assumes the design answers each APB access phase and has latency one.
`timescale 1ns/1ns
module bit_field_extract_tb_top;
  import bfe_pkg::*;
  localparam logic [SRC_W-1:0] OP = 128'h76543210_FEDCBA98_01234567_89ABCDEF;
  logic                   clk;
  logic                   rstn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [AW-1:0]          paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic [SRC_W-1:0]       operand;
  logic                   operand_valid;
  logic [LANES*OUT_W-1:0] result;
  logic                   result_valid;
  logic [31:0]            rd;
  logic                   er;
  int                     bad_count;
  int                     checks;
  bfe_top i_bfe_top (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .OPERAND(operand), .OPERAND_VALID(operand_valid),
    .RESULT(result), .RESULT_VALID(result_valid));
  bfe_dp_model i_bfe_dp_model (.clk(clk), .operand(operand),
    .operand_valid(operand_valid), .result(result), .result_valid(result_valid));
  always #2 clk = ~clk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pull(input logic [LANES*OUT_W-1:0] exp);
    int n;
    logic [LANES*OUT_W-1:0] g;
    n = 0;
    while (i_bfe_dp_model.got_q.size() == 0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    g = 'x;
    if (i_bfe_dp_model.got_q.size() > 0) begin
      g = i_bfe_dp_model.got_q.pop_front();
    end
    for (int i = 0; i < LANES; i++) begin
      chk(g[32*i+:32], exp[32*i+:32]);
    end
  endtask
  task automatic run(input logic [SRC_W-1:0] op, input logic [LANES*OUT_W-1:0] exp);
    i_bfe_dp_model.put(op);
    i_bfe_dp_model.idle();
    pull(exp);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, POS_OFS, 32'h0000_0000);
    chk(rd, 32'h1810_0800);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({rd[30:0], er}, 32'h0000_0001);
    run(OP, 128'h00000089_000089AB_0089ABCD_89ABCDEF);
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    run(OP, 128'h00000089_000000AB_000000CD_000000EF);
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    apb(1'b1, POS_OFS, 32'h0302_01FF);
    run({96'h0, 32'h8000_000A}, 128'h00000001_00000000_00000001_00000001);
    apb(1'b1, CTRL_OFS, 32'h0000_0009);
    apb(1'b1, POS_OFS, 32'h1810_0800);
    i_bfe_dp_model.put(OP);
    i_bfe_dp_model.put(~OP);
    i_bfe_dp_model.idle();
    pull(128'h00000076_000000DC_00000045_000000EF);
    pull(128'h00000089_00000023_000000BA_00000010);
    apb(1'b0, RES0_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0010);
    apb(1'b1, CTRL_OFS, 32'h0000_0005);
    apb(1'b1, OUT_FMT_OFS, 32'h0000_0004);
    apb(1'b1, POS_OFS, 32'h20FC_0400);
    run({96'h0, 32'hC000_00A5}, 128'h00000000_FFFFFFFC_FFFFFFFA_00000005);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0402);
    apb(1'b1, STATUS_OFS, 32'h0000_0002);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0400);
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
    run({96'h0, 32'hC000_00A5}, 128'h00000000_00000000_00000000_00000001);
    apb(1'b1, IN_FMT_OFS, 32'h0001_0408);
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    apb(1'b1, POS_OFS, 32'h0B08_0400);
    run({96'h0, 32'h0000_F8A5}, 128'h00000001_00000008_0000008A_FFFFF8A5);
    apb(1'b0, COUNT_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, COUNT_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    stop_test();
  end
endmodule
